/* design/amc_pkg.sv */
// Package holding constants and types of the arithmetic coprocessor
package amc_pkg;

  // Operation mode codes, low four bits of the mode word
  localparam logic [3:0] AMC_OP_CLEAR = 4'h0;
  localparam logic [3:0] AMC_OP_LOAD16 = 4'h1;
  localparam logic [3:0] AMC_OP_LOAD32 = 4'h2;
  localparam logic [3:0] AMC_OP_READ = 4'h3;
  localparam logic [3:0] AMC_OP_MUL_U = 4'h4;
  localparam logic [3:0] AMC_OP_MUL_S = 4'h5;
  localparam logic [3:0] AMC_OP_MAC_S = 4'h7;
  localparam logic [3:0] AMC_OP_DIV_U = 4'h8;
  localparam logic [3:0] AMC_OP_DIV_S = 4'h9;

  // Output half select codes, high three bits of the mode word
  localparam logic [2:0] AMC_OUT_LOW = 3'h0;
  localparam logic [2:0] AMC_OUT_HIGH = 3'h1;

  // Reset values
  localparam logic [6:0] AMC_MODE_RESET = 7'h00;
  localparam logic [31:0] AMC_RESULT_RESET = 32'h0000_0000;

  // Flag bit positions in the returned C,V,Z,N nibble
  localparam int AMC_FLAG_V = 2;

  // Divider timing: one shift step per cycle
  localparam logic [4:0] AMC_DIV_STEPS = 5'h10;

  // Mode setting register layout
  typedef struct packed {
    logic [2:0] out_sel;
    logic [3:0] op;
  } amc_mode_t;

  // Sequencer states
  typedef enum logic [1:0] {
    AMC_ST_IDLE = 2'b00,
    AMC_ST_DIV = 2'b01,
    AMC_ST_FIX = 2'b10
  } amc_state_t;

endpackage : amc_pkg

/* design/amc_coproc.sv */
// Multiply, divide and multiply-accumulate coprocessor on the core's coprocessor port
`timescale 1ns/10ps

// Operation
// - Single-cycle 16x16 multiply, unsigned 0x4, signed 0x5
// - Signed MAC 0x7 adds product, flags overflow
// - Divide 16 by 16 in 18 cycles
// - Core writes 7-bit mode word; unit latches it
// - Mode bits 6:4 choose low or high half
// - Operation code 0x0 clears the result register
// - Code 0x1 loads 16-bit value into low half and zeroes high half
// - Code 0x2 loads full 32-bit value
// - Code 0x3 returns stored result without computing
// - Two operands in; selected half and flags out
// - Quotient in low half, remainder in high
// - Result register holds until next operation
module amc_coproc
  import amc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Mode word write
  input wire logic mode_word_write_instr,
  input wire logic [6:0] mode_word,
  // Operand send
  input wire logic operand_send_instr,
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  // Preload send
  input wire logic preload_send_instr,
  input wire logic [31:0] preload_value,
  // Answer to the core
  output logic [15:0] result_half,
  output logic [3:0] flags,
  output logic busy,
  output logic done
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  amc_mode_t mode_setting;
  amc_state_t state;
  amc_state_t next_state;
  logic [31:0] result;
  logic [31:0] next_result;
  amc_mode_t next_mode;
  logic [4:0] div_cnt;
  logic [15:0] div_rem;
  logic [15:0] div_quo;
  logic [15:0] div_dvsr;
  logic neg_q;
  logic neg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode; a busy divider refuses every new request

  wire idle = (state == AMC_ST_IDLE);
  wire take_mode = mode_word_write_instr && idle;
  wire take_op = operand_send_instr && idle && !mode_word_write_instr;
  wire take_pre = preload_send_instr && idle && !mode_word_write_instr && !operand_send_instr;
  wire [3:0] op = mode_setting.op;
  wire is_div = (op == AMC_OP_DIV_U) || (op == AMC_OP_DIV_S);
  wire is_sdiv = (op == AMC_OP_DIV_S);
  wire start_div = take_op && is_div;
  wire fix = (state == AMC_ST_FIX);

  ////////////////////////////////////////////////////////////////////////////
  // Multiplier and accumulator datapath

  // Operands are widened first so that the product keeps all 32 bits
  wire [31:0] prod_u = {16'h0000, operand_a} * {16'h0000, operand_b};
  wire [31:0] prod_s = $signed({{16{operand_a[15]}}, operand_a}) *
                       $signed({{16{operand_b[15]}}, operand_b});
  wire [31:0] mac_sum = 32'(result + prod_s);
  // Overflow: both addends share a sign the wrapped sum lost
  wire mac_ovf = (result[31] == prod_s[31]) && (mac_sum[31] != result[31]);

  ////////////////////////////////////////////////////////////////////////////
  // Divider datapath: restoring, magnitudes only, signs fixed at the end

  wire [15:0] abs_a = (is_sdiv && operand_a[15]) ? 16'(~operand_a + 16'h0001) : operand_a;
  wire [15:0] abs_b = (is_sdiv && operand_b[15]) ? 16'(~operand_b + 16'h0001) : operand_b;
  wire [17:0] trial = 18'({1'b0, div_rem, div_quo[15]} - {2'b00, div_dvsr});
  wire trial_ok = !trial[17];
  wire [15:0] step_rem = trial_ok ? trial[15:0] : {div_rem[14:0], div_quo[15]};
  wire [15:0] step_quo = {div_quo[14:0], trial_ok};
  wire [15:0] q_fix = neg_q ? 16'(~div_quo + 16'h0001) : div_quo;
  wire [15:0] r_fix = neg_r ? 16'(~div_rem + 16'h0001) : div_rem;

  ////////////////////////////////////////////////////////////////////////////
  // Next result; anything not listed leaves the register untouched

  always_comb
  begin
    next_result = result;
    next_mode = take_mode ? amc_mode_t'(mode_word) : mode_setting;
    if (take_mode && (mode_word[3:0] == AMC_OP_CLEAR))
      next_result = AMC_RESULT_RESET;
    else if (take_op)
    begin
      case (op)
        AMC_OP_MUL_U: next_result = prod_u;
        AMC_OP_MUL_S: next_result = prod_s;
        AMC_OP_MAC_S: next_result = mac_sum;
        default: next_result = result;
      endcase
    end
    else if (take_pre)
    begin
      case (op)
        AMC_OP_LOAD16: next_result = {16'h0000, preload_value[15:0]};
        AMC_OP_LOAD32: next_result = preload_value;
        default: next_result = result;
      endcase
    end
    else if (fix)
      next_result = {r_fix, q_fix};
  end

  // Sequencer
  always_comb
  begin
    case (state)
      AMC_ST_IDLE: next_state = start_div ? AMC_ST_DIV : AMC_ST_IDLE;
      AMC_ST_DIV: next_state = (div_cnt == 5'h01) ? AMC_ST_FIX : AMC_ST_DIV;
      AMC_ST_FIX: next_state = AMC_ST_IDLE;
      default: next_state = AMC_ST_IDLE;
    endcase
  end

  wire done_now = (take_op && !is_div) || take_pre || fix;
  // Half chosen by the mode in force after this edge
  wire [15:0] next_half = (next_mode.out_sel == AMC_OUT_HIGH) ? next_result[31:16]
                                                              : next_result[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= AMC_ST_IDLE;
      mode_setting <= amc_mode_t'(AMC_MODE_RESET);
      result <= AMC_RESULT_RESET;
    end
    else
    begin
      state <= next_state;
      mode_setting <= next_mode;
      result <= next_result;
    end
  end

  // Divider working registers; one quotient bit per cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      div_cnt <= 5'h00;
      div_rem <= 16'h0000;
      div_quo <= 16'h0000;
      div_dvsr <= 16'h0000;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
    end
    else if (start_div)
    begin
      div_cnt <= AMC_DIV_STEPS;
      div_rem <= 16'h0000;
      div_quo <= abs_a;
      div_dvsr <= abs_b;
      neg_q <= is_sdiv && (operand_a[15] ^ operand_b[15]);
      neg_r <= is_sdiv && operand_a[15];
    end
    else if (state == AMC_ST_DIV)
    begin
      div_cnt <= 5'(div_cnt - 5'h01);
      div_rem <= step_rem;
      div_quo <= step_quo;
    end
  end

  // Answer registers; flags hold until the next answer
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      result_half <= 16'h0000;
      flags <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      result_half <= next_half;
      busy <= (next_state != AMC_ST_IDLE);
      done <= done_now;
      if (done_now)
        flags <= (take_op && (op == AMC_OP_MAC_S) && mac_ovf) ? 4'h4 : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_take_div_u;
    take_op && (op == AMC_OP_DIV_U) && (operand_b != 16'h0000);
  endsequence

  sequence s_div_wait;
    (!done)[*8] ##1 (!done)[*8] ##1 (!done) ##1 done;
  endsequence

  property p_mul_u;
    @(posedge clk) disable iff (!rstn)
    take_op && (op == AMC_OP_MUL_U) |=>
      done && (result == $past(operand_a) * $past(operand_b));
  endproperty
  a_mul_u: assert property (p_mul_u) else $error("unsigned product wrong");

  property p_mul_s;
    @(posedge clk) disable iff (!rstn)
    take_op && (op == AMC_OP_MUL_S) |=>
      $signed(result) == $signed($past(operand_a)) * $signed($past(operand_b));
  endproperty
  a_mul_s: assert property (p_mul_s) else $error("signed product wrong");

  property p_mac;
    @(posedge clk) disable iff (!rstn)
    take_op && (op == AMC_OP_MAC_S) |=>
      (result == 32'($past(result) + $past(prod_s))) &&
      (flags[AMC_FLAG_V] == ($past(result[31]) == $past(prod_s[31]) &&
                             result[31] != $past(result[31])));
  endproperty
  a_mac: assert property (p_mac) else $error("accumulate or overflow wrong");

  property p_div_time;
    @(posedge clk) disable iff (!rstn)
    start_div |=> busy ##0 s_div_wait;
  endproperty
  a_div_time: assert property (p_div_time) else $error("division length wrong");

  property p_div_u;
    @(posedge clk) disable iff (!rstn)
    s_take_div_u |-> ##18
      (result[15:0] == $past(operand_a, 18) / $past(operand_b, 18)) &&
      (result[31:16] == $past(operand_a, 18) % $past(operand_b, 18));
  endproperty
  a_div_u: assert property (p_div_u) else $error("quotient or remainder wrong");

  property p_mode;
    @(posedge clk) disable iff (!rstn)
    take_mode |=> (mode_setting == $past(mode_word)) &&
      (($past(mode_word[3:0]) != AMC_OP_CLEAR) || (result == 32'h0000_0000));
  endproperty
  a_mode: assert property (p_mode) else $error("mode latch or clear wrong");

  property p_load;
    @(posedge clk) disable iff (!rstn)
    take_pre && (op == AMC_OP_LOAD16 || op == AMC_OP_LOAD32) |=>
      result == (($past(op) == AMC_OP_LOAD32) ? $past(preload_value)
                                              : {16'h0000, $past(preload_value[15:0])});
  endproperty
  a_load: assert property (p_load) else $error("preload wrong");

  property p_half;
    @(posedge clk) disable iff (!rstn)
    done |-> result_half == ((mode_setting.out_sel == AMC_OUT_HIGH) ? result[31:16]
                                                                     : result[15:0]);
  endproperty
  a_half: assert property (p_half) else $error("returned half wrong");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
    (idle && !mode_word_write_instr && !preload_send_instr &&
     !(operand_send_instr && op != AMC_OP_READ && op != AMC_OP_DIV_U &&
       op != AMC_OP_DIV_S)) |=> result == $past(result);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without cause");

endmodule : amc_coproc

/* tb/amc_core_model.sv */
// Core-side model issuing coprocessor instructions
`timescale 1ns/10ps
module amc_core_model (
  // Clock and answer
  input wire logic clk,
  input wire logic done,
  // Instruction strobes and data
  output logic mw,
  output logic [6:0] word,
  output logic os,
  output logic [15:0] a,
  output logic [15:0] b,
  output logic ps,
  output logic [31:0] pv
);
  ////////////////////////////////////////////////////////////
  // Idle lines carry inverted data so stale values never pass
  initial
  begin
    {mw, os, ps} = 3'h0;
    {word, a, b, pv} = '0;
  end

  // Only documented mode codes are ever written
  task automatic mode_wr(input logic [6:0] m);
    @(posedge clk);
    mw <= 1'b1;
    word <= m;
    @(posedge clk);
    mw <= 1'b0;
    word <= ~m;
  endtask : mode_wr

  // Bounded wait; returns cycles from take to answer
  task automatic wait_ans(output int n);
    n = 0;
    while (n < 30)
    begin
      #1;
      n++;
      if (done === 1'b1)
        break;
      @(posedge clk);
    end
  endtask : wait_ans

  // Both operands travel in one transfer
  task automatic send(input logic [15:0] x, input logic [15:0] y, output int n);
    @(posedge clk);
    os <= 1'b1;
    a <= x;
    b <= y;
    @(posedge clk);
    os <= 1'b0;
    a <= ~x;
    b <= ~y;
    wait_ans(n);
  endtask : send

  task automatic preload(input logic [31:0] v, output int n);
    @(posedge clk);
    ps <= 1'b1;
    pv <= v;
    @(posedge clk);
    ps <= 1'b0;
    pv <= ~v;
    wait_ans(n);
  endtask : preload
endmodule : amc_core_model

/* tb/amc_coproc_tb.sv */
// Self-checking bench for the arithmetic coprocessor
`timescale 1ns/10ps
module amc_coproc_tb;
  import amc_pkg::*;
  logic clk;
  logic rstn;
  logic mw, os, ps, busy, done;
  logic [6:0] word;
  logic [15:0] a, b, rh;
  logic [31:0] pv, res, st;
  logic [3:0] fl;
  logic [19:0] exp_q[$];
  logic [6:0] md[8] = '{7'h04, 7'h14, 7'h05, 7'h15, 7'h08, 7'h18, 7'h09, 7'h19};
  int n_fail, total_checks, cyc, n, nb;

  amc_coproc u_dut (.clk(clk), .rstn(rstn), .mode_word_write_instr(mw),
    .mode_word(word), .operand_send_instr(os), .operand_a(a), .operand_b(b),
    .preload_send_instr(ps), .preload_value(pv), .result_half(rh), .flags(fl),
    .busy(busy), .done(done));
  amc_core_model u_core (.clk(clk), .done(done), .mw(mw), .word(word), .os(os),
    .a(a), .b(b), .ps(ps), .pv(pv));

  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Each answer is matched against the oldest note; a hang is cut off
  // Busy cycles are counted from one answer to the next
  always @(posedge clk)
  begin
    cyc++;
    if (busy === 1'b1)
      nb++;
    if (cyc == 3000)
    begin
      n_fail++;
      give_verdict();
    end
    else if (done === 1'b1)
    begin
      nb = 0;
      if (exp_q.size() > 0)
        check("answer", 32'({fl, rh}), 32'(exp_q.pop_front()));
      else
        check("stray done", 1, 0);
    end
  end

  function automatic logic [15:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st[15:0];
  endfunction : rnd

  function automatic logic [15:0] half(input logic [6:0] m);
    return (m[6:4] == AMC_OUT_HIGH) ? res[31:16] : res[15:0];
  endfunction : half

  // Reference result kept alongside the design's register
  task automatic run(input logic [6:0] m, input logic [15:0] x, input logic [15:0] y);
    logic [31:0] p;
    logic v;
    v = 1'b0;
    p = {{16{x[15]}}, x} * {{16{y[15]}}, y};
    if (m[3:0] == AMC_OP_CLEAR)
      res = '0;
    else if (m[3:0] == AMC_OP_MUL_U)
      res = {16'h0000, x} * {16'h0000, y};
    else if (m[3:0] == AMC_OP_MUL_S)
      res = p;
    else if (m[3:0] == AMC_OP_MAC_S)
    begin
      v = (res[31] == p[31]) && ((res + p) >> 31 != res[31]);
      res = res + p;
    end
    else if (m[3:0] == AMC_OP_DIV_U)
      res = {x % y, x / y};
    else if (m[3:0] == AMC_OP_DIV_S)
      res = {$signed(x) % $signed(y), $signed(x) / $signed(y)};
    exp_q.push_back({1'b0, v, 2'b00, half(m)});
    u_core.mode_wr(m);
    u_core.send(x, y, n);
    check("latency", n, m[3] ? 18 : 1);
    check("busy cycles", nb, m[3] ? 17 : 0);
  endtask : run

  task automatic load(input logic [6:0] m, input logic [31:0] v);
    res = (m[3:0] == AMC_OP_LOAD16) ? {16'h0000, v[15:0]} : v;
    exp_q.push_back({4'h0, half(m)});
    u_core.mode_wr(m);
    u_core.preload(v, n);
  endtask : load

  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] y;
    rstn = 1'b0;
    st = 32'h0000_0047;
    res = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    check("reset", 32'(rh), 32'h0000_0000);
    for (int i = 0; i < 24; i++)
    begin
      y = rnd();
      if (y == 16'h0000 || y == 16'hffff)
        y = 16'h0003;
      run(md[i % 8], rnd(), y);
    end
    load(7'h02, 32'h7fff_fff0);
    run(7'h07, 16'h7fff, 16'h7fff);
    run(7'h17, rnd(), rnd());
    run(7'h03, 16'h1234, 16'h0005);
    load(7'h11, 32'hdead_beef);
    run(7'h03, rnd(), rnd());
    // Low half still holds the preload here, so only a real clear shows zero
    u_core.mode_wr(7'h00);
    #1;
    check("clear", 32'(rh), 32'h0000_0000);
    run(7'h10, rnd(), rnd());
    // Let the last answer reach the scoreboard before the verdict
    repeat (2) @(posedge clk);
    check("notes left", exp_q.size(), 0);
    give_verdict();
  end
endmodule : amc_coproc_tb
